// [src/ref_and_master_clock_select.sv]
// Master clock source and voltage reference control with AXI4-Lite regs.
// Assumes clock pins arrive asynchronously; the clock mux itself is modelled
// as a select plus a synchronised-level path sampled on clk_in.
`timescale 1ns/1ns
`include "refclk_consts.svh"
module ref_and_master_clock_select (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic int_osc_clk_in,
  input wire logic crystal_input_pin_in,
  input wire logic crystal_or_clock_pin_in,
  output logic crystal_or_clock_pin_out,
  output logic crystal_or_clock_pin_oe_n_out,
  output logic reference_output_pin_out,
  output logic int_ref_enable_out,
  output logic [1:0] reference_source_select_out,
  output logic [1:0] master_clock_source_select_out,
  output logic master_clock_out,
  output logic master_clock_ready_out,
  output logic modulator_tick_out
);
  // Three-stage samplers for the three asynchronous clock inputs
  logic [2:0] osc_sync_reg;
  logic [2:0] osc_sync_next;
  logic [2:0] xtal_sync_reg;
  logic [2:0] xtal_sync_next;
  logic [2:0] ext_sync_reg;
  logic [2:0] ext_sync_next;
  logic osc_lvl_reg;
  logic osc_lvl_next;
  logic xtal_lvl_reg;
  logic xtal_lvl_next;
  logic ext_lvl_reg;
  logic ext_lvl_next;
  logic [15:0] mode_reg;
  logic [15:0] mode_next;
  logic [15:0] setup0_reg;
  logic [15:0] setup0_next;
  logic aw_hold_reg;
  logic aw_hold_next;
  logic [7:0] aw_addr_reg;
  logic [7:0] aw_addr_next;
  logic w_hold_reg;
  logic w_hold_next;
  logic [31:0] w_data_reg;
  logic [31:0] w_data_next;
  logic [3:0] w_strb_reg;
  logic [3:0] w_strb_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  refclk_pkg::xtal_st_t xst_reg;
  refclk_pkg::xtal_st_t xst_next;
  logic [15:0] settle_cnt_reg;
  logic [15:0] settle_cnt_next;
  logic mclk_reg;
  logic mclk_next;
  logic mclk_prev_reg;
  logic mclk_prev_next;
  logic tick_reg;
  logic tick_next;
  logic out_reg;
  logic out_next;
  logic oe_n_reg;
  logic oe_n_next;
  refclk_pkg::clk_src_t clk_sel;
  logic do_write;
  localparam logic [15:0] SETTLE_CYC = 16'(`XTAL_SETTLE_CYC);
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] r);
    addr_is = (a[7:2] == r[7:2]);
  endfunction
  // Byte-lane merge used for both 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  assign clk_sel = refclk_pkg::clk_src_t'(mode_reg[`CLK_SEL_LSB +: 2]);
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  // Synchronisers: second and third stage agree before a level changes
  always_comb begin
    osc_sync_next = {osc_sync_reg[1:0], int_osc_clk_in};
    xtal_sync_next = {xtal_sync_reg[1:0], crystal_input_pin_in};
    ext_sync_next = {ext_sync_reg[1:0], crystal_or_clock_pin_in};
    osc_lvl_next = osc_lvl_reg;
    xtal_lvl_next = xtal_lvl_reg;
    ext_lvl_next = ext_lvl_reg;
    if (osc_sync_reg[1] == osc_sync_reg[2]) begin
      osc_lvl_next = osc_sync_reg[2];
    end
    if (xtal_sync_reg[1] == xtal_sync_reg[2]) begin
      xtal_lvl_next = xtal_sync_reg[2];
    end
    if (ext_sync_reg[1] == ext_sync_reg[2]) begin
      ext_lvl_next = ext_sync_reg[2];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      osc_sync_reg <= 3'h0;
      xtal_sync_reg <= 3'h0;
      ext_sync_reg <= 3'h0;
      osc_lvl_reg <= 1'b0;
      xtal_lvl_reg <= 1'b0;
      ext_lvl_reg <= 1'b0;
    end else begin
      osc_sync_reg <= osc_sync_next;
      xtal_sync_reg <= xtal_sync_next;
      ext_sync_reg <= ext_sync_next;
      osc_lvl_reg <= osc_lvl_next;
      xtal_lvl_reg <= xtal_lvl_next;
      ext_lvl_reg <= ext_lvl_next;
    end
  end
  // AXI4-Lite slave: address and data taken in either order
  always_comb begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    mode_next = mode_reg;
    setup0_next = setup0_reg;
    if (s_axi_awvalid && !aw_hold_reg) begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_reg) begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `AXI_OKAY;
      if (addr_is(aw_addr_reg, `MODE_REG_ADDR)) begin
        // Bit 15 enable, bits 3:2 clock select; all bits kept as written
        mode_next = merge16(mode_reg, w_data_reg, w_strb_reg);
      end else if (addr_is(aw_addr_reg, `SETUP0_REG_ADDR)) begin
        setup0_next = merge16(setup0_reg, w_data_reg, w_strb_reg);
      end else if (!addr_is(aw_addr_reg, `STATUS_REG_ADDR)) begin
        bresp_next = `AXI_SLVERR;
      end
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = `AXI_OKAY;
      rdata_next = 32'h0000_0000;
      if (addr_is(s_axi_araddr, `MODE_REG_ADDR)) begin
        rdata_next[15:0] = mode_reg;
      end else if (addr_is(s_axi_araddr, `SETUP0_REG_ADDR)) begin
        rdata_next[15:0] = setup0_reg;
      end else if (addr_is(s_axi_araddr, `STATUS_REG_ADDR)) begin
        rdata_next[3:0] = {master_clock_ready_out, mode_reg[`REF_EN_BIT],
                           clk_sel};
      end else begin
        rresp_next = `AXI_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
      // Enable set and internal oscillator code out of any reset
      mode_reg <= `MODE_REG_RESET;
      setup0_reg <= `SETUP0_REG_RESET;
    end else begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      mode_reg <= mode_next;
      setup0_reg <= setup0_next;
    end
  end

  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // Master clock mux, crystal settle wait, and pin drive
  always_comb begin
    xst_next = xst_reg;
    settle_cnt_next = settle_cnt_reg;
    out_next = 1'b0;
    oe_n_next = 1'b1;
    mclk_next = osc_lvl_reg;
    unique case (clk_sel)
      refclk_pkg::CLK_INT: mclk_next = osc_lvl_reg;
      refclk_pkg::CLK_INT_OUT: begin
        mclk_next = osc_lvl_reg;
        // Driving the pin costs dc performance, so it is opt-in only
        out_next = osc_lvl_reg;
        oe_n_next = 1'b0;
      end
      refclk_pkg::CLK_EXT: mclk_next = ext_lvl_reg;
      refclk_pkg::CLK_XTAL: mclk_next = xtal_lvl_reg;
    endcase
    // Ready is held low while a newly picked crystal starts up
    unique case (xst_reg)
      refclk_pkg::ST_RUN: begin
        if (clk_sel != refclk_pkg::CLK_XTAL) begin
          settle_cnt_next = 16'h0000;
        end else if (settle_cnt_reg == 16'h0000) begin
          xst_next = refclk_pkg::ST_SETTLE;
          settle_cnt_next = SETTLE_CYC;
        end
      end
      refclk_pkg::ST_SETTLE: begin
        if (clk_sel != refclk_pkg::CLK_XTAL) begin
          xst_next = refclk_pkg::ST_RUN;
          settle_cnt_next = 16'h0000;
        end else if (settle_cnt_reg == 16'h0001) begin
          xst_next = refclk_pkg::ST_RUN;
          settle_cnt_next = 16'hFFFF;
        end else begin
          settle_cnt_next = settle_cnt_reg - 16'h0001;
        end
      end
      default: begin
        xst_next = refclk_pkg::ST_RUN;
        settle_cnt_next = 16'h0000;
      end
    endcase
    mclk_prev_next = mclk_reg;
    // Rate tick follows master clock edges, so rates scale with it
    tick_next = mclk_reg && !mclk_prev_reg;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      xst_reg <= refclk_pkg::ST_RUN;
      settle_cnt_reg <= 16'h0000;
      mclk_reg <= 1'b0;
      mclk_prev_reg <= 1'b0;
      tick_reg <= 1'b0;
      out_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      xst_reg <= xst_next;
      settle_cnt_reg <= settle_cnt_next;
      mclk_reg <= mclk_next;
      mclk_prev_reg <= mclk_prev_next;
      tick_reg <= tick_next;
      out_reg <= out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign crystal_or_clock_pin_out = out_reg;
  assign crystal_or_clock_pin_oe_n_out = oe_n_reg;
  assign master_clock_out = mclk_reg;
  // Host must still hold its serial clock until this rises
  assign master_clock_ready_out = (xst_reg == refclk_pkg::ST_RUN);
  assign modulator_tick_out = tick_reg;
  assign int_ref_enable_out = mode_reg[`REF_EN_BIT];
  assign reference_output_pin_out = mode_reg[`REF_EN_BIT];
  // Software clears the enable when unused
  assign reference_source_select_out =
    setup0_reg[`REF_SEL_LSB +: 2];
  assign master_clock_source_select_out = clk_sel;
endmodule

// [src/refclk_consts.svh]
// Constants for the reference and master clock select block.
// Assumes inclusion by bare name from the src folder.
`ifndef REFCLK_CONSTS_SVH
`define REFCLK_CONSTS_SVH
`define MODE_REG_IDX 8'h01
`define SETUP0_REG_IDX 8'h20
`define MODE_REG_ADDR 8'h04
`define SETUP0_REG_ADDR 8'h80
`define STATUS_REG_ADDR 8'h84
`define MODE_REG_RESET 16'h8000
`define SETUP0_REG_RESET 16'h1320
`define REF_EN_BIT 15
`define CLK_SEL_LSB 2
`define REF_SEL_LSB 4
`define CLK_NOMINAL_MHZ 16
`define SYS_CLK_MHZ 25
`define XTAL_SETTLE_US 64
`define XTAL_SETTLE_CYC ((`XTAL_SETTLE_US * `SYS_CLK_MHZ))
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// [src/refclk_pkg.sv]
// Types for the reference and master clock select block.
// Assumes nothing beyond the constants header.
package refclk_pkg;
  typedef enum logic [1:0] {
    CLK_INT = 2'h0,
    CLK_INT_OUT = 2'h1,
    CLK_EXT = 2'h2,
    CLK_XTAL = 2'h3
  } clk_src_t;
  typedef enum logic [1:0] {
    REF_EXT = 2'h0,
    REF_RSVD1 = 2'h1,
    REF_INT = 2'h2,
    REF_AVDD = 2'h3
  } ref_src_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_SETTLE = 2'h1
  } xtal_st_t;
endpackage

// [verification/refclk_sva.sv]
// Concurrent checks for the reference and master clock select block.
// Assumes a bind onto the top module; one clock domain, async reset.
`timescale 1ns/1ns
`include "refclk_consts.svh"
module refclk_sva (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic crystal_or_clock_pin_out,
  input wire logic crystal_or_clock_pin_oe_n_out,
  input wire logic reference_output_pin_out,
  input wire logic int_ref_enable_out,
  input wire logic [1:0] reference_source_select_out,
  input wire logic [1:0] master_clock_source_select_out,
  input wire logic master_clock_out,
  input wire logic master_clock_ready_out,
  input wire logic modulator_tick_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  wire logic [1:0] sel = master_clock_source_select_out;
  AST_REF_PIN: assert property (
    reference_output_pin_out == int_ref_enable_out)
    else $error("reference pin differs from enable");
  AST_REF_RESET: assert property (
    $fell(rst_in) |-> reference_output_pin_out && int_ref_enable_out)
    else $error("reference off after reset");
  AST_REFSEL_RESET: assert property (
    $fell(rst_in) |-> reference_source_select_out == 2'h2)
    else $error("reference source not internal after reset");
  AST_CLK_RESET: assert property (
    $fell(rst_in) |-> sel == 2'h0 && master_clock_ready_out)
    else $error("clock source not internal after reset");
  // One cycle of slack: the enable is registered from the select
  AST_OE_CODE: assert property (
    $stable(sel) |-> crystal_or_clock_pin_oe_n_out == (sel != 2'h1))
    else $error("pin enable does not match clock code");
  AST_PIN_QUIET: assert property (
    $stable(sel) && sel != 2'h1 |-> !crystal_or_clock_pin_out)
    else $error("shared pin driven without output code");
  AST_TICK_EDGE: assert property (
    $rose(master_clock_out) |-> ##[0:1] modulator_tick_out)
    else $error("no tick on master clock edge");
  AST_TICK_PULSE: assert property (
    modulator_tick_out |=> !modulator_tick_out)
    else $error("tick longer than one cycle");
  AST_XTAL_SETTLE: assert property (
    $rose(sel == 2'h3) |-> ##[0:2] !master_clock_ready_out)
    else $error("no settle after crystal select");
  AST_READY_OTHER: assert property (
    $stable(sel) && sel != 2'h3 |-> master_clock_ready_out)
    else $error("clock not ready outside crystal mode");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cover property ($rose(master_clock_ready_out));
  cover property (!crystal_or_clock_pin_oe_n_out);
  cover property (s_axi_bvalid && s_axi_bresp == `AXI_SLVERR);
endmodule

bind ref_and_master_clock_select refclk_sva i_sva (.*);

// [verification/test_ref_and_master_clock_select.sv]
// Self-checking bench for the reference and master clock select block.
// Assumes the design's constants header; clocks on pins are slow squares.
`timescale 1ns/1ns
`include "refclk_consts.svh"
module test_ref_and_master_clock_select;
  logic clk_in, rst_in, ext_clk;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, reference_source_select_out;
  logic [1:0] master_clock_source_select_out;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, int_osc_clk_in, crystal_input_pin_in;
  logic crystal_or_clock_pin_in, crystal_or_clock_pin_out;
  logic crystal_or_clock_pin_oe_n_out, reference_output_pin_out;
  logic int_ref_enable_out, master_clock_out, master_clock_ready_out;
  logic modulator_tick_out;
  logic [31:0] d;
  logic [1:0] r;
  int miscompares, compares, cycles, c8, c12, n;
  ref_and_master_clock_select i_dut (.*);
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Oscillator period 16, crystal 8, external 24 cycles
  always @(posedge clk_in) begin
    c8 <= (c8 == 7) ? 0 : c8 + 1;
    c12 <= (c12 == 11) ? 0 : c12 + 1;
    if (c8 == 7) int_osc_clk_in <= ~int_osc_clk_in;
    if (c8[1:0] == 2'h3) crystal_input_pin_in <= ~crystal_input_pin_in;
    if (c12 == 11) ext_clk <= ~ext_clk;
    // Shared pin level: design wins only while its enable is low
    crystal_or_clock_pin_in <= crystal_or_clock_pin_oe_n_out ?
      ext_clk : crystal_or_clock_pin_out;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_range(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("unexpected at %0t: count %0d not in %0d..%0d", $time, got,
        lo, hi);
    end
  endtask
  // Handshakes judged at the falling edge, acted on at the next rise
  // A nonzero lag keeps the response ready low for that many cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input int lag = 0);
    logic aw, w, b;
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    b = 1'b0;
    while (!b) begin
      @(negedge clk_in);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clk_in);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      if (lag > 0) begin
        lag--;
        if (lag == 0) s_axi_bready <= 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input int lag = 0);
    logic ar, rv;
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    rv = 1'b0;
    while (!rv) begin
      @(negedge clk_in);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_in);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv) s_axi_rready <= 1'b0;
      if (lag > 0) begin
        lag--;
        if (lag == 0) s_axi_rready <= 1'b1;
      end
    end
  endtask
  task automatic t_reset();
    check(reference_output_pin_out, 1);
    check(reference_source_select_out, 2'h2);
    check(master_clock_source_select_out, 2'h0);
    rd(`MODE_REG_ADDR);
    check(d, {16'h0000, `MODE_REG_RESET});
    rd(`SETUP0_REG_ADDR);
    check(d, {16'h0000, `SETUP0_REG_RESET});
    $display("t_reset done");
  endtask
  task automatic t_ref();
    wr(`MODE_REG_ADDR, 32'h0000_0000);
    check(int_ref_enable_out, 0);
    check(reference_output_pin_out, 0);
    wr(`SETUP0_REG_ADDR, 32'h0000_1300);
    check(reference_source_select_out, 2'h0);
    rd(`SETUP0_REG_ADDR);
    check(d, 32'h0000_1300);
    wr(`MODE_REG_ADDR, 32'h0000_8000);
    check(reference_output_pin_out, 1);
    // Slow response ready: the slave must hold its answer meanwhile
    wr(`SETUP0_REG_ADDR, {16'h0000, `SETUP0_REG_RESET}, 4);
    check(reference_source_select_out, 2'h2);
    rd(`SETUP0_REG_ADDR, 4);
    check(d, {16'h0000, `SETUP0_REG_RESET});
    $display("t_ref done");
  endtask
  task automatic t_clk();
    int exp_ticks[4] = '{480 / 16, 480 / 16, 480 / 24, 480 / 8};
    int hi, pin;
    for (int code = 0; code < 4; code++) begin
      wr(`MODE_REG_ADDR, 32'h0000_8000 | (code << `CLK_SEL_LSB));
      // Pin enable and ready are registered one edge after the write
      @(negedge clk_in);
      check(master_clock_source_select_out, code);
      check(crystal_or_clock_pin_oe_n_out, code != 1);
      if (code == 3) begin
        check(master_clock_ready_out, 0);
        n = 0;
        // Host waits for crystal startup before using the clock
        while (master_clock_ready_out !== 1'b1 && n < 3000) begin
          @(negedge clk_in);
          n++;
        end
        check_range(n, `XTAL_SETTLE_CYC - 8, `XTAL_SETTLE_CYC + 8);
      end
      repeat (16) @(posedge clk_in);
      n = 0;
      hi = 0;
      pin = 0;
      repeat (480) begin
        @(negedge clk_in);
        if (modulator_tick_out === 1'b1) n++;
        if (master_clock_out === 1'b1) hi++;
        if (crystal_or_clock_pin_out === 1'b1) pin++;
      end
      check_range(n, exp_ticks[code] - 1, exp_ticks[code] + 1);
      check_range(hi, 236, 244);
      check_range(pin, code == 1 ? 236 : 0, code == 1 ? 244 : 0);
    end
    $display("t_clk done");
  endtask
  task automatic t_err();
    wr(8'h10, 32'h0000_FFFF);
    check(r, `AXI_SLVERR);
    rd(8'h10);
    check(r, `AXI_SLVERR);
    wr(`STATUS_REG_ADDR, 32'h0000_0000);
    check(r, `AXI_OKAY);
    rd(`STATUS_REG_ADDR);
    check(d, 32'h0000_000F);
    $display("t_err done");
  endtask
  // Second reset while the crystal is selected
  task automatic t_rerst();
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    check(master_clock_source_select_out, 2'h0);
    rd(`MODE_REG_ADDR);
    check(d, {16'h0000, `MODE_REG_RESET});
    $display("t_rerst done");
  endtask
  initial begin
    rst_in = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, ext_clk} = 3'h0;
    {int_osc_clk_in, crystal_input_pin_in, crystal_or_clock_pin_in} = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {c8, c12, cycles} = {32'd0, 32'd0, 32'd0};
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_ref();
    t_clk();
    t_err();
    t_rerst();
    finish_test();
  end
endmodule
